// ---- qsh_pkg.sv ----
// Overview of operation
// RQ1: Event bits latch at one and stay until explicitly cleared.
// RQ2: Reading an event register clears it; clear-status clears all event registers.
// RQ3: Instrument reset and device clear leave event registers untouched.
// RQ4: Event read returns binary-weighted value of set bits.
// RQ5: Summary bit is OR of event bits gated by enable bits.
// RQ6: Enable registers are readable and writable; reading leaves them intact.
// RQ7: Clear-status leaves enable registers unchanged.
// RQ8: Output summaries feed instrument register; its summary drives questionable bit 13.
// RQ9: Questionable bit 4 latches on fan fault.
// RQ10: Questionable bit 13 latches on enabled instrument summary.
// RQ11: Instrument bit 1 from output one summary, bit 2 from output two.
// RQ12: Output event bit 0 latches on voltage loss, bit 1 on current loss.
// RQ13: Output event bit 9 latches on overvoltage trip.
// RQ14: Condition register shows live regulation mode bits, not latched.
// RQ15: Writing zero to questionable enable clears all its mask bits.
// RQ16: Controller writes 6 to instrument enable, 515 to output enables.
// RQ17: Break command aborts operation and discards output data like device clear.
// RQ18: Summary bits recomputed combinationally every cycle from events and enables.
package qsh_pkg;

  localparam int REG_W = 16;
  localparam int NUM_OUT = 2;

  // Bit positions
  localparam int QS_FAN_BIT = 4;
  localparam int QS_INST_BIT = 13;
  localparam int INST_OUT1_BIT = 1;
  localparam int INST_OUT2_BIT = 2;
  localparam int OUT_VOLT_BIT = 0;
  localparam int OUT_CURR_BIT = 1;
  localparam int OUT_OVP_BIT = 9;
  localparam int COND_CONST_CURR_BIT = 0;
  localparam int COND_CONST_VOLT_BIT = 1;

  localparam logic [15:0] REG_ZERO = 16'h0000;

  // Register selectors on the command port
  typedef enum logic [2:0] {
    QSH_SEL_QS_EVENT = 3'b000,
    QSH_SEL_QS_ENABLE = 3'b001,
    QSH_SEL_INST_EVENT = 3'b010,
    QSH_SEL_INST_ENABLE = 3'b011,
    QSH_SEL_OUT_EVENT = 3'b100,
    QSH_SEL_OUT_ENABLE = 3'b101,
    QSH_SEL_OUT_COND = 3'b110
  } qsh_sel_t;

  typedef struct packed {
    logic read;
    logic write;
    qsh_sel_t sel;
    logic out_idx;
    logic [15:0] wdata;
  } qsh_cmd_t;

  // Live condition inputs of one output
  typedef struct packed {
    logic volt_unreg;
    logic curr_unreg;
    logic ovp_trip;
    logic const_voltage;
    logic const_current;
  } qsh_out_cond_t;

endpackage : qsh_pkg

// ---- qsh_event_group.sv ----
`timescale 1ns/100ps
// One event/enable pair with summary output
module qsh_event_group (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sources and controls
  input wire logic [15:0] set_bits,
  input wire logic clear_event,
  input wire logic write_enable,
  input wire logic [15:0] wdata,
  // State
  output logic [15:0] event_reg,
  output logic [15:0] enable_reg,
  output logic summary
);

  // Set wins over a read clear so a same-cycle event is kept
  always_ff @(posedge clk) begin
    if (reset) begin
      event_reg <= qsh_pkg::REG_ZERO;
    end else if (clear_event) begin
      event_reg <= set_bits; // RQ2
    end else begin
      event_reg <= event_reg | set_bits; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= qsh_pkg::REG_ZERO;
    end else if (write_enable) begin
      enable_reg <= wdata; // RQ6 RQ15
    end
  end

  assign summary = |(event_reg & enable_reg); // RQ5 RQ18

endmodule : qsh_event_group

// ---- qsh_status_top.sv ----
`timescale 1ns/100ps
module qsh_status_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register command port
  input wire qsh_pkg::qsh_cmd_t cmd,
  output logic [15:0] rdata,
  output logic rvalid,
  // Housekeeping commands
  input wire logic clear_status,
  input wire logic instrument_reset,
  input wire logic device_clear,
  input wire logic break_char,
  output logic abort_operation,
  output logic discard_output,
  // Conditions
  input wire logic fan_fault,
  input wire qsh_pkg::qsh_out_cond_t out_cond [2],
  // Summary out
  output logic questionable_summary
);

  logic [15:0] qs_set;
  logic [15:0] inst_set;
  logic [15:0] out_set [2];
  logic [15:0] qs_event, qs_enable, inst_event, inst_enable;
  logic [15:0] out_event [2];
  logic [15:0] out_enable [2];
  logic [15:0] out_cond_live [2];
  logic out_summary [2];
  logic inst_summary;
  logic qs_clear, inst_clear, qs_wr, inst_wr;
  logic out_clear [2];
  logic out_wr [2];
  logic [15:0] rdata_next;

  function automatic logic hit(input qsh_pkg::qsh_cmd_t c, input qsh_pkg::qsh_sel_t s);
    hit = c.sel == s;
  endfunction : hit

  // Instrument reset and device clear never touch event storage
  assign qs_clear = clear_status | (cmd.read & hit(cmd, qsh_pkg::QSH_SEL_QS_EVENT)); // RQ2 RQ3
  assign inst_clear = clear_status | (cmd.read & hit(cmd, qsh_pkg::QSH_SEL_INST_EVENT)); // RQ2
  assign qs_wr = cmd.write & hit(cmd, qsh_pkg::QSH_SEL_QS_ENABLE); // RQ7
  assign inst_wr = cmd.write & hit(cmd, qsh_pkg::QSH_SEL_INST_ENABLE);

  for (genvar i = 0; i < qsh_pkg::NUM_OUT; i++) begin : g_out
    always_comb begin
      out_set[i] = qsh_pkg::REG_ZERO;
      out_set[i][qsh_pkg::OUT_VOLT_BIT] = out_cond[i].volt_unreg; // RQ12
      out_set[i][qsh_pkg::OUT_CURR_BIT] = out_cond[i].curr_unreg; // RQ12
      out_set[i][qsh_pkg::OUT_OVP_BIT] = out_cond[i].ovp_trip; // RQ13
      out_cond_live[i] = qsh_pkg::REG_ZERO;
      out_cond_live[i][qsh_pkg::COND_CONST_VOLT_BIT] = out_cond[i].const_voltage; // RQ14
      out_cond_live[i][qsh_pkg::COND_CONST_CURR_BIT] = out_cond[i].const_current; // RQ14
    end
    assign out_clear[i] = clear_status |
      (cmd.read & hit(cmd, qsh_pkg::QSH_SEL_OUT_EVENT) & (cmd.out_idx == 1'(i)));
    assign out_wr[i] = cmd.write & hit(cmd, qsh_pkg::QSH_SEL_OUT_ENABLE) &
      (cmd.out_idx == 1'(i));
    qsh_event_group u_out (
      .clk(clk),
      .reset(reset),
      .set_bits(out_set[i]),
      .clear_event(out_clear[i]),
      .write_enable(out_wr[i]),
      .wdata(cmd.wdata),
      .event_reg(out_event[i]),
      .enable_reg(out_enable[i]),
      .summary(out_summary[i])
    );
  end

  always_comb begin
    inst_set = qsh_pkg::REG_ZERO;
    inst_set[qsh_pkg::INST_OUT1_BIT] = out_summary[0]; // RQ11 RQ8
    inst_set[qsh_pkg::INST_OUT2_BIT] = out_summary[1]; // RQ11 RQ8
    qs_set = qsh_pkg::REG_ZERO;
    qs_set[qsh_pkg::QS_FAN_BIT] = fan_fault; // RQ9
    qs_set[qsh_pkg::QS_INST_BIT] = inst_summary; // RQ10 RQ8
  end

  qsh_event_group u_inst (
    .clk(clk),
    .reset(reset),
    .set_bits(inst_set),
    .clear_event(inst_clear),
    .write_enable(inst_wr),
    .wdata(cmd.wdata),
    .event_reg(inst_event),
    .enable_reg(inst_enable),
    .summary(inst_summary)
  );

  qsh_event_group u_qs (
    .clk(clk),
    .reset(reset),
    .set_bits(qs_set),
    .clear_event(qs_clear),
    .write_enable(qs_wr),
    .wdata(cmd.wdata),
    .event_reg(qs_event),
    .enable_reg(qs_enable),
    .summary(questionable_summary)
  );

  // Read returns the plain binary-weighted word
  always_comb begin
    unique case (cmd.sel)
      qsh_pkg::QSH_SEL_QS_EVENT: rdata_next = qs_event; // RQ4
      qsh_pkg::QSH_SEL_QS_ENABLE: rdata_next = qs_enable; // RQ6
      qsh_pkg::QSH_SEL_INST_EVENT: rdata_next = inst_event; // RQ4
      qsh_pkg::QSH_SEL_INST_ENABLE: rdata_next = inst_enable;
      qsh_pkg::QSH_SEL_OUT_EVENT: rdata_next = out_event[cmd.out_idx]; // RQ4
      qsh_pkg::QSH_SEL_OUT_ENABLE: rdata_next = out_enable[cmd.out_idx];
      qsh_pkg::QSH_SEL_OUT_COND: rdata_next = out_cond_live[cmd.out_idx]; // RQ14
      default: rdata_next = qsh_pkg::REG_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= qsh_pkg::REG_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= cmd.read;
      if (cmd.read) begin
        rdata <= rdata_next;
      end
    end
  end

  // Break acts exactly as device clear; outputs are registered copies of the requests, one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      abort_operation <= 1'b0;
      discard_output <= 1'b0;
    end else begin
      abort_operation <= device_clear | break_char | instrument_reset; // RQ17
      discard_output <= device_clear | break_char; // RQ17
    end
  end

endmodule : qsh_status_top

// ---- qsh_status_chk.sv ----
`timescale 1ns/100ps
module qsh_status_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire qsh_pkg::qsh_cmd_t cmd,
  input wire logic [15:0] rdata,
  // Clear requests
  input wire logic device_clear,
  input wire logic break_char,
  input wire logic discard_output,
  // Conditions
  input wire logic fan_fault,
  input wire qsh_pkg::qsh_out_cond_t out_cond [2],
  input wire logic questionable_summary
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [3:0] rs;
  logic [1:0] live;
  assign rs = {cmd.read, cmd.sel};
  assign live = {out_cond[cmd.out_idx].const_voltage, out_cond[cmd.out_idx].const_current};
  a_discard_follows: assert property (device_clear || break_char |=> discard_output)
    else $error("no discard");
  a_cond_live: assert property (rs == 4'he |=> rdata == {14'h0, $past(live)})
    else $error("bad condition");
  a_fan_latch: assert property (rs == 4'h8 && $past(fan_fault) && !$past(reset) |=> rdata[4])
    else $error("fan lost");
  a_qs_unused: assert property (rs == 4'h8 |=> (rdata & 16'hdfef) == 16'h0)
    else $error("qs bits");
  a_inst_unused: assert property (rs == 4'ha |=> (rdata & 16'hfff9) == 16'h0)
    else $error("inst bits");
  a_out_unused: assert property (rs == 4'hc |=> (rdata & 16'hfdfc) == 16'h0)
    else $error("out bits");
  a_hole_zero: assert property (rs == 4'hf |=> rdata == 16'h0)
    else $error("hole read");
  a_mask_zero: assert property (cmd.write && cmd.sel == 3'h1 && cmd.wdata == 16'h0
    |=> !questionable_summary)
    else $error("mask kept");
  c_chain: cover property (rs == 4'h8 ##1 rdata[13]);
  c_summary: cover property (questionable_summary);
  c_break: cover property (break_char ##1 discard_output);
endmodule : qsh_status_chk
bind qsh_status_top qsh_status_chk u_chk (
  .clk(clk),
  .reset(reset),
  .cmd(cmd),
  .rdata(rdata),
  .device_clear(device_clear),
  .break_char(break_char),
  .discard_output(discard_output),
  .fan_fault(fan_fault),
  .out_cond(out_cond),
  .questionable_summary(questionable_summary)
);

// ---- qsh_ctrl_model.sv ----
`timescale 1ns/100ps
module qsh_ctrl_model (
  // Bus side
  input wire logic clk,
  input wire logic [15:0] rdata,
  output qsh_pkg::qsh_cmd_t cmd
);
  initial cmd = '0;
  // Held across one rising edge, read data taken after it
  task automatic req(input logic r, input logic [2:0] s, input logic i,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    cmd <= '{r, !r, qsh_pkg::qsh_sel_t'(s), i, d};
    @(negedge clk);
    cmd <= '0;
    q = rdata;
  endtask : req
  task automatic arm();
    logic [15:0] q;
    req(1'b0, 3'h5, 1'b0, 16'h0203, q);
    req(1'b0, 3'h5, 1'b1, 16'h0203, q);
    req(1'b0, 3'h3, 1'b0, 16'h0006, q);
    req(1'b0, 3'h1, 1'b0, 16'h2000, q);
  endtask : arm
endmodule : qsh_ctrl_model

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic clk = 0, reset = 1, clear_status = 0, instrument_reset = 0, device_clear = 0;
  logic break_char = 0, fan_fault = 0, rvalid, abort_operation, discard_output;
  logic questionable_summary;
  logic [15:0] rdata, q;
  qsh_pkg::qsh_cmd_t cmd;
  qsh_pkg::qsh_out_cond_t out_cond [2] = '{default: '0};
  int err_total = 0, comparisons = 0, cycles = 0;
  qsh_status_top i_qsh_status_top (
    .clk(clk),
    .reset(reset),
    .cmd(cmd),
    .rdata(rdata),
    .rvalid(rvalid),
    .clear_status(clear_status),
    .instrument_reset(instrument_reset),
    .device_clear(device_clear),
    .break_char(break_char),
    .abort_operation(abort_operation),
    .discard_output(discard_output),
    .fan_fault(fan_fault),
    .out_cond(out_cond),
    .questionable_summary(questionable_summary)
  );
  qsh_ctrl_model u_ctrl (
    .clk(clk),
    .rdata(rdata),
    .cmd(cmd)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [2:0] s, input logic i, input logic [15:0] exp);
    u_ctrl.req(1'b1, s, i, 16'h0, q);
    check(q, exp);
    check({15'h0, rvalid}, 16'h0001);
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse
  // Write to an event register must not land
  task automatic t_fan();
    pulse(fan_fault);
    u_ctrl.req(1'b0, 3'h0, 1'b0, 16'hffff, q);
    rd(3'h0, 1'b0, 16'h0010);
    rd(3'h7, 1'b0, 16'h0000);
    rd(3'h0, 1'b0, 16'h0000);
  endtask : t_fan
  task automatic t_chain();
    u_ctrl.arm();
    @(negedge clk);
    out_cond[0] = 5'b10100;
    out_cond[1] = 5'b01000;
    @(negedge clk);
    out_cond = '{default: '0};
    repeat (3) @(negedge clk);
    check({15'h0, questionable_summary}, 16'h0001);
    rd(3'h4, 1'b0, 16'h0201);
    rd(3'h4, 1'b1, 16'h0002);
    rd(3'h2, 1'b0, 16'h0006);
    rd(3'h0, 1'b0, 16'h2000);
  endtask : t_chain
  task automatic t_clear();
    pulse(fan_fault);
    pulse(instrument_reset);
    pulse(device_clear);
    check({14'h0, abort_operation, discard_output}, 16'h0003);
    pulse(break_char);
    check({14'h0, abort_operation, discard_output}, 16'h0003);
    rd(3'h0, 1'b0, 16'h0010);
    pulse(fan_fault);
    pulse(clear_status);
    rd(3'h0, 1'b0, 16'h0000);
    rd(3'h3, 1'b0, 16'h0006);
    rd(3'h3, 1'b0, 16'h0006);
    // Summary must be high before the zero write, or the mask check proves nothing
    u_ctrl.req(1'b0, 3'h1, 1'b0, 16'h0010, q);
    pulse(fan_fault);
    check({15'h0, questionable_summary}, 16'h0001);
    u_ctrl.req(1'b0, 3'h1, 1'b0, 16'h0000, q);
    check({15'h0, questionable_summary}, 16'h0000);
    rd(3'h1, 1'b0, 16'h0000);
  endtask : t_clear
  task automatic t_cond();
    for (int k = 0; k < 4; k++) begin
      out_cond[1] = 5'(k);
      rd(3'h6, 1'b1, 16'(k));
    end
  endtask : t_cond
  initial begin
    repeat (5) @(negedge clk);
    reset = 0;
    t_fan();
    t_chain();
    t_clear();
    t_cond();
    give_verdict();
  end
endmodule : testbench
